// file: pocc_defs.vh
// Constants for the packet and overlap command control block
//------------------------------------------------------------
// Contract
// [R1] Every reset kind leaves the packet-device signature in the registers.
// [R2] Identify-device is aborted and the packet signature is presented.
// [R3] Device reset command resets only this device, not the other one.
// [R4] Host should not soft-reset during a packet command.
// [R5] Packet command: busy while preparing, then request data and drop busy.
// [R6] Packet words come by PIO; last word sets busy, clears request. On release after the packet [R11] the code leaves busy clear.
// [R7] Bus release clears both busy and data request.
// [R8] Host disables interrupts on current device before selecting the other.
// [R9] Only NOP non-zero subcommand, packet, queued DMA and service may release.
// [R10] Overlap request bit sampled from features when packet command issued.
// [R11] Overlap supported, requested, release interrupt on: release after packet.
// [R12] Ready released command sets service; interrupt only if selected and enabled.
// [R13] Host issues service command after a service request.
// [R14] Overlap with release interrupt off: complete now if ready, else release.
// [R15] Queued DMA: complete now if ready, else release and ask service later.
// [R16] Service is signalled only while this device is selected.
// [R17] Auto-poll NOP only reports error, outstanding command kept.
// [R18] Host adapter with auto-poll answers that NOP itself.
// [R19] Pending interrupt clears on status read or command write.
//------------------------------------------------------------
`ifndef POCC_DEFS_VH
`define POCC_DEFS_VH
// Register offsets on the task-file port
`define POCC_REG_DATA 3'h0
`define POCC_REG_FEAT 3'h1
`define POCC_REG_SECCNT 3'h2
`define POCC_REG_LBALO 3'h3
`define POCC_REG_LBAMID 3'h4
`define POCC_REG_LBAHI 3'h5
`define POCC_REG_DEVSEL 3'h6
`define POCC_REG_CMD 3'h7
// Status bit positions
`define POCC_ST_ERR 0
`define POCC_ST_DRQ 3
`define POCC_ST_SERV 4
`define POCC_ST_DRDY 6
`define POCC_ST_BSY 7
// Field positions
`define POCC_FEAT_OVL 1
`define POCC_DEV_BIT 4
`define POCC_CTL_NIEN 1
// Error register abort code
`define POCC_ERR_ABRT 8'h04
// Command codes
`define POCC_CMD_NOP 8'h00
`define POCC_CMD_DEVRST 8'h08
`define POCC_CMD_PACKET 8'hA0
`define POCC_CMD_SERVICE 8'hA2
`define POCC_CMD_IDENT 8'hEC
`define POCC_CMD_RDQ 8'hC7
`define POCC_CMD_WRQ 8'hCC
// Packet-device signature
`define POCC_SIG_SECCNT 8'h01
`define POCC_SIG_LBALO 8'h01
`define POCC_SIG_LBAMID 8'h14
`define POCC_SIG_LBAHI 8'hEB
// Packet length in words and preparation delay in cycles
`define POCC_PKT_WORDS 4'h6
`define POCC_PREP_CYC 4'h4
`endif

// file: pocc_pkt_mem.v
// Small memory holding the received command packet words
`timescale 1ns/1ns
module pocc_pkt_mem (
	clk,
	wr_en,
	wr_addr,
	wr_data,
	rd_addr,
	rd_data
);
	input wire clk;
	input wire wr_en;
	input wire [2:0] wr_addr;
	input wire [15:0] wr_data;
	input wire [2:0] rd_addr;
	output reg [15:0] rd_data;

	reg [15:0] mem [0:7];

	// Write port and registered read
	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// file: pocc_core.v
// Device-side packet command, overlap and service control
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "pocc_defs.vh"
module pocc_core (
	clk,
	sys_rst,
	dev_id,
	bus_addr,
	bus_wdata,
	bus_wr,
	bus_rd,
	bus_rdata,
	ctl_wr,
	ctl_wdata,
	soft_rst,
	ovl_support,
	rel_int_en,
	op_ready,
	op_done,
	pkt_rd_addr,
	pkt_rd_data,
	cmd_active,
	cmd_released,
	intrq
);
	input wire clk;
	input wire sys_rst;
	input wire dev_id;
	input wire [2:0] bus_addr;
	input wire [15:0] bus_wdata;
	input wire bus_wr;
	input wire bus_rd;
	output reg [15:0] bus_rdata;
	input wire ctl_wr;
	input wire [7:0] ctl_wdata;
	input wire soft_rst;
	input wire ovl_support;
	input wire rel_int_en;
	input wire op_ready;
	input wire op_done;
	input wire [2:0] pkt_rd_addr;
	output wire [15:0] pkt_rd_data;
	output reg cmd_active;
	output reg cmd_released;
	output reg intrq;

	//--------------------------------------------------------
	// States
	//--------------------------------------------------------
	localparam S_IDLE = 6'b000001;
	localparam S_PREP = 6'b000010;
	localparam S_PKT = 6'b000100;
	localparam S_EXEC = 6'b001000;
	localparam S_REL = 6'b010000;
	localparam S_DONE = 6'b100000;

	//--------------------------------------------------------
	// State and task-file registers
	//--------------------------------------------------------
	reg [5:0] state_r;
	reg bsy_r;
	reg drq_r;
	reg err_r;
	reg serv_r;
	reg [7:0] error_r;
	reg [7:0] feat_r;
	reg [7:0] seccnt_r;
	reg [7:0] lbalo_r;
	reg [7:0] lbamid_r;
	reg [7:0] lbahi_r;
	reg [7:0] devsel_r;
	reg nien_r;
	reg ovl_r;
	reg may_rel_r;
	reg pend_r;
	reg [3:0] cnt_r;
	reg [2:0] widx_r;

	//--------------------------------------------------------
	// Bus decode
	//--------------------------------------------------------
	wire selected = (devsel_r[`POCC_DEV_BIT] == dev_id);
	wire [7:0] cmd = bus_wdata[7:0];
	wire cmd_wr = bus_wr && (bus_addr == `POCC_REG_CMD) && selected;
	wire stat_rd = bus_rd && (bus_addr == `POCC_REG_CMD) && selected;
	wire data_wr = bus_wr && (bus_addr == `POCC_REG_DATA) && selected && drq_r;
	wire last_word = data_wr && ({1'b0, widx_r} == `POCC_PKT_WORDS - 4'h1);
	wire [7:0] status = {bsy_r, 1'b1, 1'b0, serv_r, drq_r, 2'b00, err_r};
	wire do_reset = sys_rst || soft_rst || (cmd_wr && cmd == `POCC_CMD_DEVRST);

	//--------------------------------------------------------
	// Packet store
	//--------------------------------------------------------
	pocc_pkt_mem u_mem (
		.clk(clk),
		.wr_en(data_wr),
		.wr_addr(widx_r),
		.wr_data(bus_wdata),
		.rd_addr(pkt_rd_addr),
		.rd_data(pkt_rd_data)
	);

	//--------------------------------------------------------
	// Host-written registers
	//--------------------------------------------------------
	// Device control register, nIEN bit
	always @(posedge clk) begin
		if (sys_rst) begin
			nien_r <= 1'b0;
		end else if (ctl_wr) begin
			nien_r <= ctl_wdata[`POCC_CTL_NIEN];
		end
	end

	// Task file writes not tied to the command flow
	always @(posedge clk) begin
		if (sys_rst) begin
			devsel_r <= 8'h00;
			feat_r <= 8'h00;
		end else if (bus_wr) begin
			if (bus_addr == `POCC_REG_DEVSEL) begin
				devsel_r <= bus_wdata[7:0];
			end
			if (bus_addr == `POCC_REG_FEAT) begin
				feat_r <= bus_wdata[7:0];
			end
		end
	end

	//--------------------------------------------------------
	// Command engine
	//--------------------------------------------------------
	always @(posedge clk) begin
		if (do_reset) begin
			// Only this device: device reset is decoded with selection [R3] [R1]
			state_r <= S_IDLE;
			bsy_r <= 1'b0;
			drq_r <= 1'b0;
			err_r <= 1'b0;
			serv_r <= 1'b0;
			error_r <= 8'h00;
			seccnt_r <= `POCC_SIG_SECCNT; // [R1]
			lbalo_r <= `POCC_SIG_LBALO;
			lbamid_r <= `POCC_SIG_LBAMID;
			lbahi_r <= `POCC_SIG_LBAHI;
			ovl_r <= 1'b0;
			may_rel_r <= 1'b0;
			cnt_r <= 4'h0;
			widx_r <= 3'h0;
			cmd_active <= 1'b0;
			cmd_released <= 1'b0;
		end else begin
			if (bus_wr && !bsy_r && !drq_r) begin
				if (bus_addr == `POCC_REG_SECCNT) seccnt_r <= bus_wdata[7:0];
				if (bus_addr == `POCC_REG_LBALO) lbalo_r <= bus_wdata[7:0];
				if (bus_addr == `POCC_REG_LBAMID) lbamid_r <= bus_wdata[7:0];
				if (bus_addr == `POCC_REG_LBAHI) lbahi_r <= bus_wdata[7:0];
			end
			if (cmd_wr && cmd == `POCC_CMD_NOP) begin
				// Auto-poll or plain NOP: error only, released command kept [R17]
				err_r <= 1'b1;
				error_r <= `POCC_ERR_ABRT;
			end else if (cmd_wr && cmd == `POCC_CMD_IDENT && !bsy_r && !drq_r) begin
				// Abort and show the packet signature [R2]
				err_r <= 1'b1;
				error_r <= `POCC_ERR_ABRT;
				seccnt_r <= `POCC_SIG_SECCNT;
				lbalo_r <= `POCC_SIG_LBALO;
				lbamid_r <= `POCC_SIG_LBAMID;
				lbahi_r <= `POCC_SIG_LBAHI;
			end else if (cmd_wr && cmd == `POCC_CMD_SERVICE && state_r == S_REL) begin
				// Resume the released command
				serv_r <= 1'b0;
				bsy_r <= 1'b1;
				cmd_released <= 1'b0;
				state_r <= S_EXEC;
				may_rel_r <= 1'b0;
			end else begin
				case (state_r)
				S_IDLE: begin
					if (cmd_wr && cmd == `POCC_CMD_PACKET) begin
						bsy_r <= 1'b1; // [R5]
						err_r <= 1'b0;
						error_r <= 8'h00;
						ovl_r <= feat_r[`POCC_FEAT_OVL]; // [R10]
						cnt_r <= 4'h0;
						widx_r <= 3'h0;
						cmd_active <= 1'b1;
						state_r <= S_PREP;
					end else if (cmd_wr && (cmd == `POCC_CMD_RDQ || cmd == `POCC_CMD_WRQ)) begin
						bsy_r <= 1'b1;
						err_r <= 1'b0;
						may_rel_r <= 1'b1; // [R15] [R9]
						cmd_active <= 1'b1;
						state_r <= S_EXEC;
					end
				end
				S_PREP: begin
					// Count out the preparation time
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == `POCC_PREP_CYC - 4'h1) begin
						bsy_r <= 1'b0; // [R5]
						drq_r <= 1'b1;
						state_r <= S_PKT;
					end
				end
				S_PKT: begin
					// Store words until the last one arrives
					if (data_wr) begin
						widx_r <= widx_r + 3'h1; // [R6]
					end
					if (last_word) begin
						drq_r <= 1'b0; // [R6]
						if (ovl_r && ovl_support && rel_int_en) begin
							bsy_r <= 1'b0; // [R11] [R7]
							cmd_released <= 1'b1;
							state_r <= S_REL;
						end else begin
							bsy_r <= 1'b1;
							may_rel_r <= ovl_r && ovl_support; // [R14]
							state_r <= S_EXEC;
						end
					end
				end
				S_EXEC: begin
					// Finish, or give the bus up when allowed and not ready
					if (op_done) begin
						bsy_r <= 1'b0;
						state_r <= S_DONE;
					end else if (may_rel_r && !op_ready) begin
						bsy_r <= 1'b0; // [R7] [R14] [R15]
						cmd_released <= 1'b1;
						state_r <= S_REL;
					end
				end
				S_REL: begin
					// Back end ready again: raise the service request
					if (op_ready) begin
						serv_r <= 1'b1; // [R12]
					end
				end
				S_DONE: begin
					// One cycle to drop the active flag
					cmd_active <= 1'b0;
					state_r <= S_IDLE;
				end
				default: begin
					state_r <= S_IDLE;
				end
				endcase
			end
		end
	end

	//--------------------------------------------------------
	// Interrupt
	//--------------------------------------------------------
	// Pending interrupt: set on completion or service, set wins over clear
	always @(posedge clk) begin
		if (do_reset) begin
			pend_r <= 1'b0;
		end else if ((state_r == S_EXEC && op_done)
			|| (state_r == S_REL && op_ready && !serv_r)) begin
			pend_r <= 1'b1; // [R12]
		end else if (stat_rd || cmd_wr) begin
			pend_r <= 1'b0; // [R19]
		end
	end

	// Interrupt line gated by selection and nIEN
	always @(posedge clk) begin
		if (sys_rst) begin
			intrq <= 1'b0;
		end else begin
			intrq <= pend_r && selected && !nien_r; // [R12] [R16] [R8]
		end
	end

	//--------------------------------------------------------
	// Read port
	//--------------------------------------------------------
	// Read data, one cycle after the strobe
	always @(posedge clk) begin
		if (sys_rst) begin
			bus_rdata <= 16'h0000;
		end else if (bus_rd && selected) begin
			case (bus_addr)
			`POCC_REG_DATA: bus_rdata <= 16'h0000;
			`POCC_REG_FEAT: bus_rdata <= {8'h00, error_r};
			`POCC_REG_SECCNT: bus_rdata <= {8'h00, seccnt_r};
			`POCC_REG_LBALO: bus_rdata <= {8'h00, lbalo_r};
			`POCC_REG_LBAMID: bus_rdata <= {8'h00, lbamid_r};
			`POCC_REG_LBAHI: bus_rdata <= {8'h00, lbahi_r};
			`POCC_REG_DEVSEL: bus_rdata <= {8'h00, devsel_r};
			`POCC_REG_CMD: bus_rdata <= {8'h00, status}; // [R16]
			default: bus_rdata <= 16'h0000;
			endcase
		end else begin
			bus_rdata <= 16'h0000;
		end
	end
endmodule

// file: pocc_core_chk.sv
// Port checker for the packet and overlap command control block
`timescale 1ns/1ns
module pocc_core_chk (
	input wire clk,
	input wire sys_rst,
	input wire [2:0] bus_addr,
	input wire [15:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	input wire [15:0] bus_rdata,
	input wire ctl_wr,
	input wire [7:0] ctl_wdata,
	input wire soft_rst,
	input wire ovl_support,
	input wire rel_int_en,
	input wire op_ready,
	input wire op_done,
	input wire cmd_active,
	input wire cmd_released,
	input wire intrq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Status read, command write and a quiet back end
	wire st_rd = bus_rd && bus_addr == 3'h7;
	wire cmd_wr = bus_wr && bus_addr == 3'h7;
	wire calm = !op_ready && !op_done;
	chk_rst_idle: assert property (disable iff (1'b0) sys_rst |=> !intrq && !cmd_active)
		else $error("busy after reset");
	chk_soft_idle: assert property (soft_rst |=> !cmd_active && !cmd_released)
		else $error("busy after soft reset");
	chk_rel_flags: assert property (st_rd && cmd_released |=> !bus_rdata[7] && !bus_rdata[3])
		else $error("released but busy");
	chk_rel_cause: assert property ($rose(cmd_released) |->
		$past(ovl_support) && $past(rel_int_en) || !$past(op_ready)) else $error("bad release");
	chk_nien_mask: assert property (ctl_wr && ctl_wdata[1] ##1 !ctl_wr |=> !intrq)
		else $error("intrq while disabled");
	chk_rd_clear: assert property (st_rd && calm ##1 calm |=> !intrq)
		else $error("intrq after status read");
	chk_cmd_clear: assert property (cmd_wr && bus_wdata[7:0] == 8'hA0 && calm
		##1 calm |=> !intrq) else $error("intrq after command");
	chk_nop_keep: assert property (cmd_wr && bus_wdata[7:0] == 8'h00 && cmd_released
		|=> cmd_released) else $error("no-op dropped command");
	// Main scenarios reached
	cov_rel: cover property ($rose(cmd_released));
	cov_irq: cover property ($rose(intrq));
	cov_nop: cover property (cmd_wr && bus_wdata[7:0] == 8'h00 && cmd_released);
endmodule
bind pocc_core pocc_core_chk u_pocc_core_chk (.clk, .sys_rst, .bus_addr, .bus_wdata, .bus_wr,
	.bus_rd, .bus_rdata, .ctl_wr, .ctl_wdata, .soft_rst, .ovl_support, .rel_int_en, .op_ready,
	.op_done, .cmd_active, .cmd_released, .intrq);

// file: pocc_host_adp.sv
// Host adapter model: passes strobes on, answers the auto-poll no-op itself
`timescale 1ns/1ns
module pocc_host_adp (
	input wire clk,
	input wire ap_en,
	input wire h_wr,
	input wire h_rd,
	input wire [2:0] bus_addr,
	input wire [7:0] h_cmd,
	input wire [15:0] bus_rdata,
	output wire bus_wr,
	output wire bus_rd,
	output wire [15:0] h_rdata
);
	reg poll_r = 1'b0;
	reg ans_r = 1'b0;
	// No-op kept from the device while auto-poll is on
	wire nop = ap_en && h_wr && bus_addr == 3'h7 && h_cmd == 8'h00;
	assign bus_wr = h_wr && !nop;
	assign bus_rd = h_rd;
	assign h_rdata = ans_r ? 16'h0040 : bus_rdata;
	// Next status read is answered here with the error bit clear
	always @(posedge clk) begin
		ans_r <= h_rd && bus_addr == 3'h7 && poll_r;
		poll_r <= nop || (poll_r && !ans_r);
	end
endmodule

// file: pocc_core_test.sv
// Bench for the packet and overlap command control block
`timescale 1ns/1ns
`include "pocc_defs.vh"
module pocc_core_test;
	reg clk = 1'b0, sys_rst = 1'b1, h_wr = 1'b0, h_rd = 1'b0, ctl_wr = 1'b0, soft_rst = 1'b0;
	reg ap_en = 1'b0, op_ready = 1'b0, op_done = 1'b0, ovl_support = 1'b0, rel_int_en = 1'b0;
	reg [2:0] bus_addr = 3'h0;
	reg [15:0] bus_wdata = 16'h0000, d;
	reg [7:0] ctl_wdata = 8'h00;
	reg [2:0] pkt_ra = 3'h0;
	wire bus_wr, bus_rd, cmd_active, cmd_released, intrq;
	wire [15:0] bus_rdata, h_rdata, pkt_rd_data;
	int num_errors = 0, cmp_count = 0;
	initial forever #10 clk = ~clk;
	// Device 0 behind the host adapter
	pocc_core u_pocc_core (.clk, .sys_rst, .dev_id(1'b0), .bus_addr, .bus_wdata, .bus_wr,
		.bus_rd, .bus_rdata, .ctl_wr, .ctl_wdata, .soft_rst, .ovl_support, .rel_int_en,
		.op_ready, .op_done, .pkt_rd_addr(pkt_ra), .pkt_rd_data, .cmd_active, .cmd_released,
		.intrq);
	pocc_host_adp u_pocc_host_adp (.clk, .ap_en, .h_wr, .h_rd, .bus_addr,
		.h_cmd(bus_wdata[7:0]), .bus_rdata, .bus_wr, .bus_rd, .h_rdata);
	// Compare and count
	task chk(input [15:0] got, input [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cb(input got, input exp);
		chk({15'h0, got}, {15'h0, exp});
	endtask
	// Register port cycles
	task wr(input [2:0] a, input [15:0] v);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= v;
		h_wr <= 1'b1;
		@(posedge clk);
		h_wr <= 1'b0;
	endtask
	task rc(input [2:0] a, input [15:0] m, input [15:0] e);
		@(posedge clk);
		bus_addr <= a;
		h_rd <= 1'b1;
		@(posedge clk);
		h_rd <= 1'b0;
		#1 d = h_rdata;
		chk(d & m, e);
	endtask
	task ctl(input [7:0] v);
		@(posedge clk);
		ctl_wdata <= v;
		ctl_wr <= 1'b1;
		@(posedge clk);
		ctl_wr <= 1'b0;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Back end finishes the open command
	task fin;
		@(posedge clk);
		op_done <= 1'b1;
		@(posedge clk);
		op_done <= 1'b0;
		cyc(3);
	endtask
	task sig;
		rc(3'h2, 16'h00FF, {8'h00, `POCC_SIG_SECCNT});
		rc(3'h3, 16'h00FF, {8'h00, `POCC_SIG_LBALO});
		rc(3'h4, 16'h00FF, {8'h00, `POCC_SIG_LBAMID});
		rc(3'h5, 16'h00FF, {8'h00, `POCC_SIG_LBAHI});
	endtask
	task wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		rc(3'h7, 16'hFFFF, 16'h0040);
		sig;
		wr(3'h7, 16'h00EC);
		rc(3'h7, 16'h0089, 16'h0001);
		rc(3'h1, 16'h00FF, 16'h0004);
		sig;
		$display("reset and identify done");
		// Pass 0 plain, pass 1 overlap without release interrupt, pass 2 full overlap
		for (int o = 0; o < 3; o++) begin
			ovl_support <= (o != 0);
			rel_int_en <= (o == 2);
			wr(3'h1, (o != 0) ? 16'h0002 : 16'h0000);
			wr(3'h7, 16'h00A0);
			rc(3'h7, 16'h0088, 16'h0080);
			cyc(5);
			rc(3'h7, 16'h0088, 16'h0008);
			for (int i = 0; i < 6; i++)
				wr(3'h0, 16'h1000 | 16'(o * 8 + i));
			rc(3'h7, 16'h0088, o ? 16'h0000 : 16'h0080);
			cb(cmd_released, o != 0);
			// Stored packet words read back through the packet port
			for (int i = 0; i < 6; i++) begin
				@(posedge clk);
				pkt_ra <= 3'(i);
				@(posedge clk);
				#1 chk(pkt_rd_data, 16'h1000 | 16'(o * 8 + i));
			end
			if (o == 0) begin
				fin;
				cb(intrq, 1'b1);
				rc(3'h7, 16'h0088, 16'h0000);
				cyc(2);
				cb(intrq, 1'b0);
			end
			if (o == 1) begin
				wr(3'h7, 16'h00A2);
				rc(3'h7, 16'h0088, 16'h0080);
				fin;
				cb(cmd_released, 1'b0);
			end
		end
		wr(3'h7, 16'h0000);
		rc(3'h7, 16'h0089, 16'h0001);
		cb(cmd_released, 1'b1);
		ap_en <= 1'b1;
		wr(3'h7, 16'h0000);
		rc(3'h7, 16'hFFFF, 16'h0040);
		ap_en <= 1'b0;
		ctl(8'h02);
		wr(3'h6, 16'h0010);
		op_ready <= 1'b1;
		cyc(4);
		cb(intrq, 1'b0);
		rc(3'h7, 16'hFFFF, 16'h0000);
		wr(3'h6, 16'h0000);
		rc(3'h7, 16'h0010, 16'h0010);
		ctl(8'h00);
		wr(3'h7, 16'h00A2);
		op_ready <= 1'b0;
		fin;
		cb(cmd_released, 1'b0);
		$display("packet and overlap done");
		for (int q = 0; q < 2; q++) begin
			wr(3'h7, q ? 16'h00CC : 16'h00C7);
			cyc(4);
			cb(cmd_released, 1'b1);
			rc(3'h7, 16'h0088, 16'h0000);
			if (q == 0) begin
				wr(3'h6, 16'h0010);
				wr(3'h7, 16'h0008);
				cyc(1);
				cb(cmd_released, 1'b1);
				wr(3'h6, 16'h0000);
				wr(3'h7, 16'h0008);
			end else begin
				@(posedge clk);
				soft_rst <= 1'b1; // No packet command open here
				@(posedge clk);
				soft_rst <= 1'b0;
			end
			cyc(2);
			cb(cmd_active, 1'b0);
			sig;
		end
		$display("queued and resets done");
		wrap_up;
	end
endmodule
